// File: hdl/prpd_top.sv
// reference path, detector outputs, lock indicator and prescaler with an AHB-Lite register slave
//
// Overview of operation
// R1: mode 001 runs crystal oscillator; reference divider counts unless in standby.
// R2: standby in crystal mode keeps oscillator running, reference divider stopped.
// R3: mode 000 stops the oscillator regardless of standby.
// R4: mode seven drives reference input divided by sixteen on the buffer output.
// R5: mode three passes the reference input to the buffer output undivided.
// R6: after reset the buffer output divides by eight without any programming.
// R7: software avoids one-to-one above 10 MHz and ratio two above 20 MHz.
// R8: software should pick mode two when the buffer output is unused.
// R9: invert low: sink when feedback leads, source when it lags, else float.
// R10: invert high: source when feedback leads, sink when it lags.
// R11: single-ended output floats when deselected or when standby is set.
// R12: pair pulses low on feedback line when leading, reference line when lagging; invert swaps.
// R13: when matched both pair lines stay high except one coincident short low pulse.
// R14: pair lines rest high when disabled or in standby.
// R15: lock indicator is the AND of the two pair lines.
// R16: lock indicator enable bit; cleared at reset so the indicator sits low.
// R17: prescaler divides by 65 with modulus control low, by 64 when high.
// R18: both current-select bits high select full current; others select fractions.
// R19: choice high enables single-ended output, pair high; low enables pair only.
// R20: invert bit flips single-ended sense and swaps pair roles; cleared at reset.
// R21: detector compares rising edges of divided reference and feedback, no dead zone.
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "prpd_params.svh"

module prpd_top #(
	parameter int RDIV_W = 13
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  ce_i,
	// ahb-lite slave
	input  wire logic                  hsel_i,
	input  wire logic [31:0]           haddr_i,
	input  wire prpd_pkg::prpd_htrans_t htrans_i,
	input  wire logic                  hwrite_i,
	input  wire prpd_pkg::prpd_hsize_t hsize_i,
	input  wire logic [31:0]           hwdata_i,
	input  wire logic                  hready_i,
	output logic [31:0]                hrdata_o,
	output logic                       hreadyout_o,
	output logic                       hresp_o,
	// reference path
	input  wire logic                  osc_input_pin_i,
	output logic                       osc_buffer_output_o,
	output logic                       osc_enable_o,
	output logic                       divided_reference_pulse_o,
	// loop side
	input  wire logic                  divided_feedback_pulse_i,
	output logic                       single_ended_detector_out_o,
	output logic                       single_ended_detector_oe_o,
	output logic [1:0]                 detector_current_o,
	output logic                       pair_ref_n_o,
	output logic                       pair_fb_n_o,
	output logic                       lock_indicator_o,
	// prescaler
	input  wire logic                  vco_tick_i,
	input  wire logic                  modulus_ctrl_i,
	output logic                       prescaler_pulse_o
);
	import prpd_pkg::*;

	// ======================================================================
	// elaboration check: divider width must hold the reset ratio and fit the field
	if (RDIV_W < 5 || RDIV_W > 16) begin : g_bad_rdiv_w
		$error("RDIV_W must lie between 5 and 16");
	end

	// ======================================================================
	// register state
	logic [7:0]        ctrl;
	prpd_mode_t        ref_mode;
	logic [RDIV_W-1:0] rdiv;
	logic              wr_pend;
	logic [7:0]        addr_q;
	prpd_state_t       run_state;
	logic              standby_bit_q;
	logic              osc_in_q;
	logic [RDIV_W-1:0] rcnt;
	logic [2:0]        hcnt;
	logic [6:0]        pcnt;
	logic              ref_ahead;
	logic              fb_ahead;

	// ======================================================================
	// bus decode; only whole-word single transfers are expected
	wire addr_phase = hsel_i & hready_i & htrans_i[1];
	wire wr_ctrl    = wr_pend & (addr_q == `PRPD_OFS_CTRL);
	wire wr_refcfg  = wr_pend & (addr_q == `PRPD_OFS_REFCFG);

	wire [7:0]        next_ctrl  = wr_ctrl ? (hwdata_i[7:0] & `PRPD_CTRL_MASK) : ctrl;
	wire prpd_mode_t  next_mode  = wr_refcfg ? hwdata_i[`PRPD_REF_MODE_MSB:`PRPD_REF_MODE_LSB] : ref_mode;
	wire [RDIV_W-1:0] next_rdiv  = wr_refcfg ? hwdata_i[`PRPD_REF_RDIV_LSB +: RDIV_W] : rdiv;

	// ======================================================================
	// configuration fields
	wire inv     = ctrl[`PRPD_CTRL_INV];
	wire choice  = ctrl[`PRPD_CTRL_CHOICE];
	wire lock_en = ctrl[`PRPD_CTRL_LOCKEN];
	wire standby_bit    = ctrl[`PRPD_CTRL_STANDBY_BIT];

	// ======================================================================
	// read mux uses post-write values so a read right after a write sees it
	wire [7:0]  rd_addr    = haddr_i[7:0];
	wire [31:0] rd_ctrl    = {24'h000000, next_ctrl};
	wire [31:0] rd_refcfg  = {{(16 - RDIV_W){1'b0}}, next_rdiv, 13'h0000, next_mode};
	wire [31:0] rd_status  = {26'h0000000, (run_state == PRPD_ST_RESYNC), pcnt == 7'h00,
				osc_enable_o, pair_fb_n_o, pair_ref_n_o, lock_indicator_o};
	wire [31:0] rd_mux     = (rd_addr == `PRPD_OFS_CTRL)   ? rd_ctrl :
				(rd_addr == `PRPD_OFS_REFCFG) ? rd_refcfg :
				(rd_addr == `PRPD_OFS_STATUS) ? rd_status : 32'h00000000;

	// bus slave: zero wait states, always OKAY
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend     <= 1'b0;
			addr_q      <= 8'h00;
			hrdata_o    <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else if (ce_i) begin
			wr_pend     <= addr_phase & hwrite_i;
			addr_q      <= haddr_i[7:0];
			hrdata_o    <= (addr_phase & ~hwrite_i) ? rd_mux : 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	// configuration registers; reset gives ratio eight, lock off, invert off
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl     <= `PRPD_CTRL_RST;                // [R16] [R20]
			ref_mode <= `PRPD_MODE_RST;                // [R6]
			rdiv     <= RDIV_W'(`PRPD_RDIV_RST);
		end else if (ce_i) begin
			ctrl     <= next_ctrl;
			ref_mode <= next_mode;
			rdiv     <= next_rdiv;
		end
	end

	// ======================================================================
	// reference input edge; the pin is taken as synchronous to the clock
	wire ref_edge = osc_input_pin_i & ~osc_in_q;

	// counting is off in shutdown mode and in standby; crystal keeps running in standby
	wire osc_run   = (ref_mode == `PRPD_MODE_XTAL);                     // [R1] [R2] [R3]
	wire rdiv_run  = (ref_mode != `PRPD_MODE_SHUT) & ~standby_bit;             // [R1] [R2] [R3]
	wire [RDIV_W-1:0] rdiv_last = (rdiv == '0) ? '0 : rdiv - RDIV_W'(1);
	wire rdiv_wrap = ref_edge & rdiv_run & (rcnt >= rdiv_last);

	// ======================================================================
	// standby exit: hold the detector until the first feedback pulse jam-loads the divider
	wire standby_bit_fall = standby_bit_q & ~standby_bit;
	wire jam_load  = (run_state == PRPD_ST_RESYNC) & divided_feedback_pulse_i & ~standby_bit;
	prpd_state_t next_state;
	assign next_state = standby_bit_fall ? PRPD_ST_RESYNC :
			    jam_load  ? PRPD_ST_RUN : run_state;
	wire pfd_enable = ~standby_bit & (run_state == PRPD_ST_RUN) & ~standby_bit_fall;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_state <= PRPD_ST_RUN;
			standby_bit_q    <= 1'b0;
		end else if (ce_i) begin
			run_state <= next_state;
			standby_bit_q    <= standby_bit;
		end
	end

	// reference divider and its pulse; held still in standby
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_in_q                  <= 1'b0;
			rcnt                      <= '0;
			divided_reference_pulse_o <= 1'b0;
			osc_enable_o              <= 1'b0;
		end else if (ce_i) begin
			osc_in_q                  <= osc_input_pin_i;
			osc_enable_o              <= osc_run;
			divided_reference_pulse_o <= rdiv_wrap;
			if (jam_load)
				rcnt <= '0;
			else if (rdiv_wrap)
				rcnt <= '0;
			else if (ref_edge & rdiv_run)                       // [R2]
				rcnt <= rcnt + RDIV_W'(1);
		end
	end

	// ======================================================================
	// buffer output divider: half-period count per mode, pass-through in mode three
	wire [2:0] half_last = (ref_mode == `PRPD_MODE_DIV16) ? 3'h7 :   // [R4]
			       (ref_mode == `PRPD_MODE_DIV8)  ? 3'h3 :   // [R6]
			       (ref_mode == `PRPD_MODE_DIV4)  ? 3'h1 : 3'h0;
	wire out_divides = ref_mode[2];
	wire out_passes  = (ref_mode == `PRPD_MODE_PASS);                // [R5]
	wire half_wrap   = ref_edge & (hcnt >= half_last);

	// modes zero to two keep the output low, which saves switching noise
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hcnt                <= 3'h0;
			osc_buffer_output_o <= 1'b0;
		end else if (ce_i) begin
			if (out_passes) begin
				hcnt                <= 3'h0;
				osc_buffer_output_o <= osc_input_pin_i;      // [R5]
			end else if (out_divides) begin
				if (half_wrap) begin
					hcnt                <= 3'h0;
					osc_buffer_output_o <= ~osc_buffer_output_o; // [R4]
				end else if (ref_edge) begin
					hcnt <= hcnt + 3'h1;
				end
			end else begin
				hcnt                <= 3'h0;
				osc_buffer_output_o <= 1'b0;                 // [R8]
			end
		end
	end

	// ======================================================================
	// phase/frequency detector core
	prpd_pfd prpd_pfd_inst (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.enable_i    (pfd_enable),
		.ref_evt_i   (divided_reference_pulse_o),          // [R21]
		.fb_evt_i    (divided_feedback_pulse_i),           // [R21]
		.ref_ahead_o (ref_ahead),
		.fb_ahead_o  (fb_ahead)
	);

	// ======================================================================
	// pair lines: feedback line pulses when feedback leads; invert swaps the lines
	wire pair_force     = choice | standby_bit;                                  // [R14] [R19]
	wire fb_line_low    = inv ? ref_ahead : fb_ahead;                     // [R12] [R20]
	wire ref_line_low   = inv ? fb_ahead : ref_ahead;                     // [R12] [R20]
	wire next_pair_fb_n  = pair_force | ~fb_line_low;                     // [R13]
	wire next_pair_ref_n = pair_force | ~ref_line_low;                    // [R13]

	// single-ended output: net error only, both flags together means float
	wire se_active  = choice & ~standby_bit;                                     // [R11] [R19]
	wire fb_leads   = fb_ahead & ~ref_ahead;
	wire fb_lags    = ref_ahead & ~fb_ahead;
	wire se_source  = inv ? fb_leads : fb_lags;                           // [R9] [R10]
	wire se_sink    = inv ? fb_lags : fb_leads;                           // [R9] [R10]
	wire next_se_oe = se_active & (se_source | se_sink);                  // [R11]

	// lock is built from the next pair values so it switches with the pair, forced low while disabled
	wire next_lock  = lock_en & next_pair_fb_n & next_pair_ref_n;        // [R15] [R16]

	// detector outputs all registered so they switch on the same edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pair_fb_n_o                 <= 1'b1;
			pair_ref_n_o                <= 1'b1;
			single_ended_detector_out_o <= 1'b0;
			single_ended_detector_oe_o  <= 1'b0;
			detector_current_o          <= 2'h0;
			lock_indicator_o            <= 1'b0;
		end else if (ce_i) begin
			pair_fb_n_o                 <= next_pair_fb_n;
			pair_ref_n_o                <= next_pair_ref_n;
			single_ended_detector_out_o <= se_source;
			single_ended_detector_oe_o  <= next_se_oe;
			detector_current_o          <= {ctrl[`PRPD_CTRL_CURHI], ctrl[`PRPD_CTRL_CURLO]}; // [R18]
			lock_indicator_o            <= next_lock;
		end
	end

	// ======================================================================
	// dual-modulus prescaler: terminal count picked by the modulus control
	wire [6:0] presc_term = modulus_ctrl_i ? `PRPD_PRESC_TERM64 : `PRPD_PRESC_TERM65; // [R17]
	wire       presc_wrap = vco_tick_i & (pcnt >= presc_term);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pcnt              <= 7'h00;
			prescaler_pulse_o <= 1'b0;
		end else if (ce_i) begin
			prescaler_pulse_o <= presc_wrap;
			if (presc_wrap)
				pcnt <= 7'h00;                             // [R17]
			else if (vco_tick_i)
				pcnt <= pcnt + 7'h01;
		end
	end

	// ======================================================================
	// checks
	a_osc_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R1] [R3]
		ce_i |=> (osc_enable_o == ($past(ref_mode) == `PRPD_MODE_XTAL)))
		else $error("oscillator enable does not follow the reference mode");

	a_rdiv_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R2]
		(ce_i && standby_bit) |=> (rcnt == $past(rcnt) && !divided_reference_pulse_o))
		else $error("reference divider moved during standby");

	a_div16_toggle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R4]
		(ce_i && ref_mode == `PRPD_MODE_DIV16 && ref_edge && hcnt == 3'h7)
		|=> (osc_buffer_output_o != $past(osc_buffer_output_o)))
		else $error("divide-by-16 output did not toggle");

	a_pass_thru: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R5]
		(ce_i && ref_mode == `PRPD_MODE_PASS) |=> (osc_buffer_output_o == $past(osc_input_pin_i)))
		else $error("pass-through output differs from input");

	a_se_float: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R11] [R19]
		(ce_i && (!choice || standby_bit)) |=> !single_ended_detector_oe_o)
		else $error("single-ended output driven while disabled");

	a_se_sense: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R9] [R10]
		(ce_i && choice && !standby_bit && ref_ahead && !fb_ahead)
		|=> (single_ended_detector_oe_o && single_ended_detector_out_o == !$past(inv)))
		else $error("single-ended sense wrong for lagging feedback");

	a_pair_lead: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R12] [R20]
		(ce_i && !choice && !standby_bit && fb_ahead && !ref_ahead)
		|=> (($past(inv) ? !pair_ref_n_o : !pair_fb_n_o) && ($past(inv) ? pair_fb_n_o : pair_ref_n_o)))
		else $error("wrong pair line pulsed for leading feedback");

	a_pair_rest: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R14]
		(ce_i && (choice || standby_bit)) |=> (pair_ref_n_o && pair_fb_n_o))
		else $error("pair lines not at rest while disabled");

	a_lock_and: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R15]
		(ce_i && lock_en) |=> (lock_indicator_o == (pair_ref_n_o && pair_fb_n_o)))
		else $error("lock indicator is not the AND of the pair");

	a_lock_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R16]
		(ce_i && !lock_en) |=> !lock_indicator_o)
		else $error("lock indicator high while disabled");

	a_presc_modulus: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R17]
		(ce_i && vco_tick_i && pcnt == 7'h3f) |=> (prescaler_pulse_o == $past(modulus_ctrl_i)))
		else $error("prescaler modulus wrong at count 63");

	a_current_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R18]
		(ce_i && ctrl[`PRPD_CTRL_CURHI] && ctrl[`PRPD_CTRL_CURLO]) |=> (detector_current_o == 2'h3))
		else $error("full current not selected");

endmodule : prpd_top

// File: inc/prpd_params.svh
// constants of the reference path and phase detector block: offsets, fields, resets
`ifndef PRPD_PARAMS_SVH
`define PRPD_PARAMS_SVH

// ==========================================================================
// register byte offsets on the bus
`define PRPD_OFS_CTRL      8'h00
`define PRPD_OFS_REFCFG    8'h04
`define PRPD_OFS_STATUS    8'h08

// ==========================================================================
// control register field positions
`define PRPD_CTRL_INV      7
`define PRPD_CTRL_CHOICE   6
`define PRPD_CTRL_LOCKEN   5
`define PRPD_CTRL_STANDBY_BIT     4
`define PRPD_CTRL_CURHI    3
`define PRPD_CTRL_CURLO    2
`define PRPD_CTRL_MASK     8'hfc
`define PRPD_CTRL_RST      8'h00

// ==========================================================================
// reference config register fields
`define PRPD_REF_MODE_LSB  0
`define PRPD_REF_MODE_MSB  2
`define PRPD_REF_RDIV_LSB  16
`define PRPD_RDIV_RST      16'h0005

// ==========================================================================
// reference mode codes
`define PRPD_MODE_SHUT     3'h0
`define PRPD_MODE_XTAL     3'h1
`define PRPD_MODE_QUIET    3'h2
`define PRPD_MODE_PASS     3'h3
`define PRPD_MODE_DIV2     3'h4
`define PRPD_MODE_DIV4     3'h5
`define PRPD_MODE_DIV8     3'h6
`define PRPD_MODE_DIV16    3'h7
`define PRPD_MODE_RST      `PRPD_MODE_DIV8

// ==========================================================================
// prescaler terminal counts: 65 states when control low, 64 when high
`define PRPD_PRESC_TERM65  7'h40
`define PRPD_PRESC_TERM64  7'h3f

`endif

// File: inc/prpd_pkg.sv
// types shared by the reference path and phase detector block
package prpd_pkg;

	// ======================================================================
	// detector run state after standby
	typedef enum logic {
		PRPD_ST_RUN,
		PRPD_ST_RESYNC
	} prpd_state_t;

	typedef logic [2:0] prpd_mode_t;
	typedef logic [1:0] prpd_htrans_t;
	typedef logic [2:0] prpd_hsize_t;

endpackage : prpd_pkg

// File: hdl/prpd_pfd.sv
// edge-driven phase/frequency detector core with coincident reset pulse
`timescale 1ns/1ps

module prpd_pfd (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	input  wire logic enable_i,
	input  wire logic ref_evt_i,
	input  wire logic fb_evt_i,
	output logic      ref_ahead_o,
	output logic      fb_ahead_o
);

	// ======================================================================
	// next state: an edge sets its flag, both flags together clear next cycle
	logic next_ref_ahead;
	logic next_fb_ahead;
	wire  both_set = ref_ahead_o & fb_ahead_o;

	// set wins over the overlap clear, so no edge is lost in a clear cycle
	assign next_ref_ahead = ref_evt_i | (ref_ahead_o & ~both_set); // [R21]
	assign next_fb_ahead  = fb_evt_i | (fb_ahead_o & ~both_set);   // [R21]

	// detector flags; one cycle of overlap gives the minimum-width pulse
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_ahead_o <= 1'b0;
			fb_ahead_o  <= 1'b0;
		end else if (ce_i) begin
			ref_ahead_o <= enable_i & next_ref_ahead; // [R13]
			fb_ahead_o  <= enable_i & next_fb_ahead;  // [R13]
		end
	end

	a_edge_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R21]
		(ce_i && enable_i && ref_evt_i) |=> ref_ahead_o)
		else $error("reference edge did not set its flag");

	a_overlap_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [R13]
		(ce_i && ref_ahead_o && fb_ahead_o && !ref_evt_i && !fb_evt_i) |=> (!ref_ahead_o && !fb_ahead_o))
		else $error("coincident flags not cleared after one cycle");

endmodule : prpd_pfd

// File: bench/prpd_loop_model.sv
// loop partner: reference oscillator, vco tick source and feedback divider
`timescale 1ns/1ps

module prpd_loop_model (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic fb_en_i,
	output logic      osc_o,
	output logic      fb_pulse_o,
	output logic      vco_tick_o
);
	// ====
	// 10 MHz reference keeps pass and divide-by-two modes legal
	localparam int REF_HALF = 5;
	localparam int FB_PER   = 3;
	int ref_cnt;
	int fb_cnt;

	// vco ticks every cycle while out of reset
	assign vco_tick_o = rst_n_i;

	// square reference, feedback pulse every few cycles when enabled
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_cnt    <= 0;
			fb_cnt     <= 0;
			osc_o      <= 1'b0;
			fb_pulse_o <= 1'b0;
		end else begin
			ref_cnt    <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
			osc_o      <= (ref_cnt == REF_HALF - 1) ? !osc_o : osc_o;
			fb_cnt     <= (fb_cnt == FB_PER - 1) ? 0 : fb_cnt + 1;
			fb_pulse_o <= fb_en_i && (fb_cnt == FB_PER - 1);
		end
	end
endmodule : prpd_loop_model

// File: bench/prpd_top_tb.sv
// self-checking bench for the reference path, detector outputs and prescaler
`timescale 1ns/1ps

module prpd_top_tb;
	import prpd_pkg::*;
	// ====
	// stimulus and observed signals
	logic         clk_sys_i = 1'b0;
	logic         rst_n_i   = 1'b0;
	logic         hsel      = 1'b0;
	logic [31:0]  haddr     = '0;
	prpd_htrans_t htrans    = 2'h0;
	logic         hwrite    = 1'b0;
	logic [31:0]  hwdata    = '0;
	logic         modulus   = 1'b0;
	logic         fb_en     = 1'b0;
	logic [31:0]  hrdata;
	logic [1:0]   cur;
	logic         hready, hresp, osc_in, osc_out, osc_en, fr, fb, se_out, se_oe, pr, pf, lock, vco, psc;
	logic [31:0]  rdv;
	int           bad_count = 0;
	int           cmp_count = 0;
	int           cyc = 0;
	int           n_ro, n_fo, n_oe, n_se, n_lb, n_low;
	wire  [2:0]   probe = {psc, fr, osc_out};

	always #5 clk_sys_i = !clk_sys_i;

	prpd_top prpd_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.osc_input_pin_i(osc_in), .osc_buffer_output_o(osc_out), .osc_enable_o(osc_en),
		.divided_reference_pulse_o(fr), .divided_feedback_pulse_i(fb), .single_ended_detector_out_o(se_out),
		.single_ended_detector_oe_o(se_oe), .detector_current_o(cur), .pair_ref_n_o(pr), .pair_fb_n_o(pf),
		.lock_indicator_o(lock), .vco_tick_i(vco), .modulus_ctrl_i(modulus), .prescaler_pulse_o(psc));

	prpd_loop_model prpd_loop_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fb_en_i(fb_en),
		.osc_o(osc_in), .fb_pulse_o(fb), .vco_tick_o(vco));

	// ====
	// shared tasks
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one single ahb-lite transfer; the wait ends only on hready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		rdv = hrdata;
	endtask : bus

	task automatic period(input int idx, input int exp, input string name);
		logic p;
		int   n;
		int   r;
		p = probe[idx];
		n = 0;
		r = 0;
		for (int i = 0; i < 400 && r < 2; i++) begin
			@(posedge clk_sys_i);
			if (probe[idx] === 1'b1 && p !== 1'b1) r++;
			if (r == 1) n++;
			p = probe[idx];
		end
		chk(name, exp, n);
	endtask : period

	task automatic quiet(input int idx, input string name);
		int hi;
		hi = 0;
		// skip the edge that still carries the previous mode
		repeat (2) @(posedge clk_sys_i);
		repeat (100) begin
			@(posedge clk_sys_i);
			if (probe[idx] !== 1'b0) hi++;
		end
		chk(name, 0, hi);
	endtask : quiet

	// settle first so flags left by the previous setup drain away
	task automatic observe(input logic exp_out, input logic len);
		n_ro = 0;
		n_fo = 0;
		n_oe = 0;
		n_se = 0;
		n_lb = 0;
		n_low = 0;
		repeat (100) @(posedge clk_sys_i);
		repeat (200) begin
			@(posedge clk_sys_i);
			if (pr === 1'b0 && pf === 1'b1) n_ro++;
			if (pr === 1'b1 && pf === 1'b0) n_fo++;
			if (pr !== 1'b1 || pf !== 1'b1) n_low++;
			if (se_oe === 1'b1) n_oe++;
			if (se_oe === 1'b1 && se_out !== exp_out) n_se++;
			if (lock !== (len & pr & pf)) n_lb++;
		end
	endtask : observe

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	// a hang counts as a mismatch
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ====
	// main sequence
	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		bus(0, 8'h00, 0);
		chk("ctrl reset", 0, rdv);
		chk("hresp okay", 0, hresp);
		bus(0, 8'h04, 0);
		chk("refcfg reset", 32'h0005_0006, rdv);
		chk("lock at reset", 0, lock);
		bus(1, 8'h0c, '1);
		bus(0, 8'h0c, 0);
		chk("unmapped", 0, rdv);
		period(0, 80, "ref out default");
		$display("test reset done");
		for (int m = 7; m >= 3; m--) begin
			bus(1, 8'h04, {16'h0005, 13'h0, 3'(m)});
			repeat (200) @(posedge clk_sys_i);
			period(0, 10 << (m - 3), "ref out ratio");
		end
		for (int m = 0; m < 3; m++) begin
			bus(1, 8'h04, {16'h0005, 13'h0, 3'(m)});
			quiet(0, "ref out low");
			chk("osc enable", 32'(m == 1), osc_en);
			if (m == 1) period(1, 50, "ref divider");
		end
		$display("test reference modes done");
		// mode two stays while the buffer output is unused
		bus(1, 8'h00, 32'h20);
		observe(1'b0, 1'b1);
		chk("ref lag pulses", 1, n_ro > 0);
		chk("fb line quiet", 0, n_fo);
		chk("lock and", 0, n_lb);
		bus(1, 8'h00, 32'ha0);
		observe(1'b0, 1'b1);
		chk("swapped lag", 1, n_fo > 0);
		chk("swapped ref quiet", 0, n_ro);
		bus(1, 8'h00, 32'h20);
		fb_en <= 1'b1;
		observe(1'b0, 1'b1);
		chk("fb lead pulses", 1, n_fo > 0);
		chk("ref line quiet", 0, n_ro);
		chk("lock and lead", 0, n_lb);
		chk("coincident pulse", 1, (n_low - n_ro - n_fo) > 0);
		$display("test pair detector done");
		fb_en <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			bus(1, 8'h00, 32'h40 | (c << 2));
			repeat (2) @(posedge clk_sys_i);
			chk("current", c, cur);
		end
		observe(1'b1, 1'b0);
		chk("se drives", 1, n_oe > 0);
		chk("se source", 0, n_se);
		chk("pair held high", 0, n_low);
		bus(1, 8'h00, 32'hc0);
		observe(1'b0, 1'b0);
		chk("se inverted", 0, n_se);
		chk("se inv drives", 1, n_oe > 0);
		bus(1, 8'h00, 32'h40);
		fb_en <= 1'b1;
		observe(1'b0, 1'b0);
		chk("se sink", 0, n_se);
		$display("test single ended done");
		bus(1, 8'h00, 32'h70);
		observe(1'b0, 1'b1);
		chk("se floats", 0, n_oe);
		chk("pair rests", 0, n_low);
		chk("lock standby", 0, n_lb);
		bus(1, 8'h04, 32'h0005_0001);
		quiet(1, "ref divider stopped");
		chk("osc standby", 1, osc_en);
		bus(1, 8'h04, 32'h0005_0000);
		repeat (4) @(posedge clk_sys_i);
		chk("osc shutdown", 0, osc_en);
		// leaving standby holds the detector until the first feedback pulse
		fb_en <= 1'b0;
		bus(1, 8'h00, 32'h00);
		repeat (2) @(posedge clk_sys_i);
		bus(0, 8'h08, 0);
		chk("resync wait", 1, rdv[5]);
		fb_en <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		bus(0, 8'h08, 0);
		chk("resync done", 0, rdv[5]);
		$display("test standby done");
		modulus <= 1'b1;
		repeat (200) @(posedge clk_sys_i);
		period(2, 64, "prescaler high");
		modulus <= 1'b0;
		repeat (200) @(posedge clk_sys_i);
		period(2, 65, "prescaler low");
		$display("test prescaler done");
		give_verdict();
	end
endmodule : prpd_top_tb
